// >>> hdl/hpc_pkg.sv
package hpc_pkg;

  // ----------------------------------------
  // command register byte addresses
  // ----------------------------------------
  localparam logic [7:0] CMD_ONE_ADDR   = 8'he5;  // synth, divider, framing
  localparam logic [7:0] CMD_TWO_ADDR   = 8'he6;  // raw configuration byte
  localparam logic [7:0] CMD_THREE_ADDR = 8'he7;  // raw configuration byte
  localparam logic [7:0] CMD_FOUR_ADDR  = 8'he8;  // raw configuration byte
  localparam logic [7:0] CMD_FIVE_ADDR  = 8'he9;  // raw configuration byte
  localparam logic [7:0] CMD_SIX_ADDR   = 8'hf3;  // raw configuration byte
  localparam logic [7:0] CMD_SEVEN_ADDR = 8'hf4;  // seven bit register

  // ----------------------------------------
  // first command register field layout
  // ----------------------------------------
  localparam int FRAMING_BIT  = 7;  // framing mode select
  localparam int DISABLE_BIT  = 6;  // synthesizer disable
  localparam int DIV_MSB      = 5;  // divider code high bit
  localparam int DIV_LSB      = 4;  // divider code low bit
  localparam int MUL_MSB      = 3;  // multiplier code high bit
  localparam int MUL_LSB      = 0;  // multiplier code low bit

  // ----------------------------------------
  // encodings and reset values
  // ----------------------------------------
  localparam logic [3:0] MUL_CODE_INVALID = 4'hf;   // synth output not valid
  localparam logic [4:0] MUL_BASE         = 5'h10;  // factor for code zero
  localparam logic [4:0] MUL_BYPASS       = 5'h01;  // reference used directly
  localparam logic [4:0] MUL_NONE         = 5'h00;  // shown for invalid code
  localparam logic [3:0] DIV_STEP         = 4'h2;   // divisor grows by two
  localparam logic [7:0] CMD_RESET        = 8'h00;  // value after reset
  localparam logic [6:0] CMD_SEVEN_RESET  = 7'h00;  // value after reset

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;    // system clock period
  localparam int SETTLE_NS     = 1000;  // loop resettle time after change
  localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;  // rounded up
  localparam logic [7:0] SETTLE_LOAD = 8'(SETTLE_CYC);  // counter preload

endpackage

// >>> hdl/hpc_clock_config.sv
// Contract
// R1: multiplier code 0..E selects factor 16..2
// R2: software never writes multiplier code F
// R3: software keeps synthesized clock near 70 MHz
// R4: divider code selects divide by 2,4,6,8
// R5: divided clock feeds loop, 10-15 MHz
// R6: disable bit bypasses synthesizer, uses reference
// R7: disable clear runs synthesizer from multiplier
// R8: framing bit one enables Z-bit insert/extract
// R9: framing bit zero carries F-bits first
// R10: seven write-only command registers, last 7-bit
// R11: first register: mode, disable, divider, multiplier
// R12: setting change restarts divider and resettle
`timescale 1ns/1ps
`default_nettype none

module hpc_clock_config
  import hpc_pkg::*;
(
  input  wire logic       i_clk_sys,          // 40 MHz system clock
  input  wire logic       i_nrst,             // synchronous reset, active low
  input  wire logic [7:0] i_addr,             // register byte address
  input  wire logic [7:0] i_wdata,            // register write data
  input  wire logic       i_wr,               // write strobe, one cycle
  input  wire logic       i_synth_tick,       // synthesizer clock edge enable
  input  wire logic       i_ref_tick,         // reference pin clock edge enable
  output logic      [4:0] o_synth_multiplier, // effective factor, 0 invalid
  output logic            o_synth_disable,    // synthesizer turned off
  output logic            o_synth_code_invalid, // code F programmed, synthesizer not disabled
  output logic      [3:0] o_hf_divisor,       // high freq clock divisor
  output logic            o_general_divided_clock_en, // divided clock pulse
  output logic            o_framing_mode_select, // 1 Z-bit mode
  output logic            o_zbit_insert_en,   // transmit Z-bit insertion
  output logic            o_zbit_extract_en,  // receive Z-bit extraction
  output logic            o_fbit_carry_en,    // F-bit in first position
  output logic            o_loop_settled,     // recovery loop may be trusted
  output logic      [7:0] o_cmd_two,          // second command byte
  output logic      [7:0] o_cmd_three,        // third command byte
  output logic      [7:0] o_cmd_four,         // fourth command byte
  output logic      [7:0] o_cmd_five,         // fifth command byte
  output logic      [7:0] o_cmd_six,          // sixth command byte
  output logic      [6:0] o_cmd_seven         // seventh command bits
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] cmd1;        // first command register
    logic [7:0] cmd2;        // second command register
    logic [7:0] cmd3;        // third command register
    logic [7:0] cmd4;        // fourth command register
    logic [7:0] cmd5;        // fifth command register
    logic [7:0] cmd6;        // sixth command register
    logic [6:0] cmd7;        // seventh command register
    logic [4:0] mult;        // effective multiplier
    logic       invalid;     // code F flag
    logic       zins;        // z-bit insertion
    logic       zext;        // z-bit extraction
    logic       fbit;        // f-bit carriage
    logic [3:0] divisor;     // current divisor
    logic [2:0] div_cnt;     // high freq ticks counted
    logic       div_pulse;   // divided clock pulse
    logic [7:0] settle_cnt;  // resettle countdown
    logic       settled;     // countdown done
  } hpc_state_t;

  hpc_state_t st;       // registered state
  hpc_state_t next_st;  // next state
  logic       hf_tick;  // selected high freq edge
  logic       changed;  // clock setting altered

  // ----------------------------------------
  // next state logic
  // ----------------------------------------
  always_comb begin
    next_st = st;
    changed = 1'b0;
    // register writes, no read path
    if (i_wr) begin
      case (i_addr)
        CMD_ONE_ADDR: begin
          next_st.cmd1 = i_wdata;  // R10
          changed = (i_wdata[DISABLE_BIT:MUL_LSB] != st.cmd1[DISABLE_BIT:MUL_LSB]);  // R12
        end
        CMD_TWO_ADDR:   next_st.cmd2 = i_wdata;  // R10
        CMD_THREE_ADDR: next_st.cmd3 = i_wdata;  // R10
        CMD_FOUR_ADDR:  next_st.cmd4 = i_wdata;  // R10
        CMD_FIVE_ADDR:  next_st.cmd5 = i_wdata;  // R10
        CMD_SIX_ADDR:   next_st.cmd6 = i_wdata;  // R10
        CMD_SEVEN_ADDR: next_st.cmd7 = i_wdata[6:0];  // R10
        default: ;  // unmapped writes ignored
      endcase
    end
    // effective multiplier from new settings
    if (next_st.cmd1[DISABLE_BIT]) begin
      next_st.mult = MUL_BYPASS;  // R6
    end else if (next_st.cmd1[MUL_MSB:MUL_LSB] == MUL_CODE_INVALID) begin
      next_st.mult = MUL_NONE;  // no valid factor
    end else begin
      next_st.mult = MUL_BASE - {1'b0, next_st.cmd1[MUL_MSB:MUL_LSB]};  // R1 R7 R11
    end
    next_st.invalid = !next_st.cmd1[DISABLE_BIT] &&
                      (next_st.cmd1[MUL_MSB:MUL_LSB] == MUL_CODE_INVALID);  // R2
    next_st.divisor = {1'b0, next_st.cmd1[DIV_MSB:DIV_LSB], 1'b0} + DIV_STEP;  // R4 R11
    // framing mode
    next_st.zins = next_st.cmd1[FRAMING_BIT];   // R8
    next_st.zext = next_st.cmd1[FRAMING_BIT];   // R8
    next_st.fbit = !next_st.cmd1[FRAMING_BIT];  // R9
    // divided clock from selected high freq edges
    next_st.div_pulse = 1'b0;
    if (changed) begin
      next_st.div_cnt = 3'h0;  // R12
    end else if (hf_tick) begin
      if ({1'b0, st.div_cnt} == st.divisor - 4'h1) begin
        next_st.div_cnt = 3'h0;
        next_st.div_pulse = 1'b1;  // R4 R5
      end else begin
        next_st.div_cnt = st.div_cnt + 3'h1;
      end
    end
    // loop resettle countdown
    if (changed) begin
      next_st.settle_cnt = SETTLE_LOAD;  // R12
    end else if (st.settle_cnt != 8'h00) begin
      next_st.settle_cnt = st.settle_cnt - 8'h01;
    end
    next_st.settled = (next_st.settle_cnt == 8'h00);  // R12
  end

  // reference pin replaces synthesizer when disabled
  assign hf_tick = st.cmd1[DISABLE_BIT] ? i_ref_tick : i_synth_tick;  // R6 R7

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      st.cmd1       <= CMD_RESET;
      st.cmd2       <= CMD_RESET;
      st.cmd3       <= CMD_RESET;
      st.cmd4       <= CMD_RESET;
      st.cmd5       <= CMD_RESET;
      st.cmd6       <= CMD_RESET;
      st.cmd7       <= CMD_SEVEN_RESET;
      st.mult       <= MUL_BASE;
      st.invalid    <= 1'b0;
      st.zins       <= 1'b0;
      st.zext       <= 1'b0;
      st.fbit       <= 1'b1;
      st.divisor    <= DIV_STEP;
      st.div_cnt    <= 3'h0;
      st.div_pulse  <= 1'b0;
      st.settle_cnt <= SETTLE_LOAD;
      st.settled    <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_synth_multiplier         = st.mult;
  assign o_synth_disable            = st.cmd1[DISABLE_BIT];
  assign o_synth_code_invalid       = st.invalid;
  assign o_hf_divisor               = st.divisor;
  assign o_general_divided_clock_en = st.div_pulse;
  assign o_framing_mode_select      = st.cmd1[FRAMING_BIT];
  assign o_zbit_insert_en           = st.zins;
  assign o_zbit_extract_en          = st.zext;
  assign o_fbit_carry_en            = st.fbit;
  assign o_loop_settled             = st.settled;
  assign o_cmd_two                  = st.cmd2;
  assign o_cmd_three                = st.cmd3;
  assign o_cmd_four                 = st.cmd4;
  assign o_cmd_five                 = st.cmd5;
  assign o_cmd_six                  = st.cmd6;
  assign o_cmd_seven                = st.cmd7;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  mult_map_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // R1
    (i_wr && i_addr == CMD_ONE_ADDR && !i_wdata[6] && i_wdata[3:0] != 4'hf)
      |=> o_synth_multiplier == 5'd16 - {1'b0, $past(i_wdata[3:0])})
    else $error("multiplier factor wrong");

  synth_run_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // R7
    (!o_synth_disable && i_synth_tick && !i_ref_tick && !(i_wr && i_addr == CMD_ONE_ADDR))
      |=> (st.div_cnt != $past(st.div_cnt)) || o_general_divided_clock_en)
    else $error("synth edge not counted");

  div_pulse_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // R4
    o_general_divided_clock_en |-> $past(hf_tick) && ($past(st.div_cnt) == 3'(o_hf_divisor - 4'h1)))
    else $error("divided clock pulse early or late");

  div_code_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // R11
    o_hf_divisor == {1'b0, st.cmd1[5:4], 1'b0} + 4'd2)
    else $error("divisor not from bits five to four");

  // divisor follows the written code: 2, 4, 6 or 8
  div_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // R4
    (i_wr && i_addr == CMD_ONE_ADDR)
      |=> o_hf_divisor == 4'h2 + 4'h2 * {2'b00, $past(i_wdata[5:4])})
    else $error("divisor does not match written code");

  bypass_ref_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // R6
    (o_synth_disable && !i_ref_tick && !(i_wr && i_addr == CMD_ONE_ADDR))
      |=> !o_general_divided_clock_en && o_synth_multiplier == 5'd1)
    else $error("bypass did not use reference");

  zbit_mode_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // R8
    (i_wr && i_addr == CMD_ONE_ADDR && i_wdata[7]) |=> o_zbit_insert_en && o_zbit_extract_en && !o_fbit_carry_en)
    else $error("z-bit mode not entered");

  fbit_mode_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // R9
    o_fbit_carry_en == !o_framing_mode_select)
    else $error("f-bit carriage mismatch");

  // framing bit cleared by a write leaves z-bit paths off
  fbit_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // R9
    (i_wr && i_addr == CMD_ONE_ADDR && !i_wdata[7])
      |=> o_fbit_carry_en && !o_zbit_insert_en && !o_zbit_extract_en)
    else $error("f-bit mode not entered");

  seven_bit_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // R10
    (i_wr && i_addr == CMD_SEVEN_ADDR) |=> o_cmd_seven == $past(i_wdata[6:0]) && $stable(o_cmd_six))
    else $error("seventh register write wrong");

  resettle_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // R12
    (i_wr && i_addr == CMD_ONE_ADDR && i_wdata[6:0] != st.cmd1[6:0]) |=> !o_loop_settled [*8])
    else $error("loop marked settled too soon");

endmodule

`default_nettype wire

// >>> test/hpc_clock_config_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module hpc_clock_config_tb_top;
  import hpc_pkg::*;
  // ----------------------------------------
  // signals and bench state
  // ----------------------------------------
  typedef struct {logic [61:0] v; int due;} hpc_note_t;
  logic        i_clk_sys, i_nrst, i_wr, i_synth_tick, i_ref_tick;  // driven inputs
  logic [7:0]  i_addr, i_wdata;                                   // write bus
  logic [4:0]  mul;                                               // factor seen
  logic [3:0]  dvs;                                               // divisor seen
  logic        dis, inv, gen, fm, zi, ze, fb, settled;            // flags seen
  logic [7:0]  c2, c3, c4, c5, c6;                                // raw bytes seen
  logic [6:0]  c7;                                                // seven bits seen
  logic [61:0] got;                                               // packed view
  logic [7:0]  m [0:6];                                           // expected bytes
  logic [7:0]  adr [0:6] = '{CMD_ONE_ADDR, CMD_TWO_ADDR, CMD_THREE_ADDR, CMD_FOUR_ADDR,
                             CMD_FIVE_ADDR, CMD_SIX_ADDR, CMD_SEVEN_ADDR};
  hpc_note_t   q [$];                                             // pending notes
  hpc_note_t   note;                                              // popped note
  int          n_mismatch, checks, cyc, tcount, pulses;          // counters

  assign got = {mul, dis, inv, dvs, fm, zi, ze, fb, c2, c3, c4, c5, c6, c7};

  hpc_clock_config hpc_clock_config_inst (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_synth_tick(i_synth_tick), .i_ref_tick(i_ref_tick), .o_synth_multiplier(mul),
    .o_synth_disable(dis), .o_synth_code_invalid(inv), .o_hf_divisor(dvs),
    .o_general_divided_clock_en(gen), .o_framing_mode_select(fm), .o_zbit_insert_en(zi),
    .o_zbit_extract_en(ze), .o_fbit_carry_en(fb), .o_loop_settled(settled), .o_cmd_two(c2),
    .o_cmd_three(c3), .o_cmd_four(c4), .o_cmd_five(c5), .o_cmd_six(c6), .o_cmd_seven(c7));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // expected outputs from the byte model
  function automatic logic [61:0] snap();
    logic [4:0] f;
    f = m[0][6] ? MUL_BYPASS : (m[0][3:0] == MUL_CODE_INVALID) ? MUL_NONE : MUL_BASE - {1'b0, m[0][3:0]};
    return {f, m[0][6], !m[0][6] && (m[0][3:0] == MUL_CODE_INVALID), {1'b0, m[0][5:4], 1'b0} + 4'h2,
            m[0][7], m[0][7], m[0][7], !m[0][7], m[1], m[2], m[3], m[4], m[5], m[6][6:0]};
  endfunction

  task automatic check(input string name, input logic [61:0] seen, input logic [61:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one write, then note the expected outputs
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    for (int k = 0; k < 7; k++) if (a == adr[k]) m[k] = d;
    q.push_back('{snap(), cyc + 1});
  endtask

  // divider pulse count over three periods, wrong tick source toggling
  task automatic gtest(input logic sd, input logic [1:0] d);
    int n;
    n = 2 * (d + 1);
    wr(CMD_ONE_ADDR, {1'b0, sd, d, 4'(n)});
    @(negedge i_clk_sys);
    pulses = 0;
    repeat (3 * n) begin
      @(posedge i_clk_sys);
      i_synth_tick <= sd ? 1'($urandom) : 1'b1;
      i_ref_tick <= sd ? 1'b1 : 1'($urandom);
    end
    @(posedge i_clk_sys);
    i_synth_tick <= 1'b0;
    i_ref_tick <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    check("divided_pulses", 62'(pulses), 62'd3);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // clock, monitor, pulse count, timeout
  // ----------------------------------------
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  // compare the oldest note once its result has landed
  always @(negedge i_clk_sys) begin
    if (q.size() > 0 && q[0].due <= cyc) begin
      note = q.pop_front();
      check("config", got, note.v);
    end
    cyc <= cyc + 1;
  end

  always @(posedge i_clk_sys) begin
    if (gen === 1'b1) pulses++;
    tcount++;
    if (tcount == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {i_nrst, i_wr, i_synth_tick, i_ref_tick, i_addr, i_wdata} = '0;
    {n_mismatch, checks, cyc, tcount, pulses} = '0;
    for (int k = 0; k < 7; k++) m[k] = CMD_RESET;
    void'($urandom(32'h21f5cf6a));
    repeat (20) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    q.push_back('{snap(), cyc + 1});
    $display("test reset done");
    // every multiplier code, synthesizer on and bypassed
    for (int c = 0; c < 16; c++) begin
      wr(CMD_ONE_ADDR, {1'($urandom), 1'b0, 2'($urandom), 4'(c)});
      wr(CMD_ONE_ADDR, {1'($urandom), 1'b1, 2'($urandom), 4'(c)});
    end
    $display("test multiplier done");
    // raw bytes, then unmapped addresses leave all unchanged
    for (int k = 1; k < 7; k++) wr(adr[k], 8'($urandom) | 8'h80);
    wr(8'hea, 8'($urandom));
    wr(8'hf5, 8'($urandom));
    $display("test raw registers done");
    for (int s = 0; s < 2; s++) for (int d = 0; d < 4; d++) gtest(1'(s), 2'(d));
    $display("test divider done");
    // resettle window after a change, none after framing only
    wr(CMD_ONE_ADDR, 8'h12);
    repeat (SETTLE_CYC - 1) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    check("settled_early", 62'(settled), 62'd0);
    repeat (1) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    check("settled_late", 62'(settled), 62'd1);
    wr(CMD_ONE_ADDR, 8'h92);
    wr(CMD_ONE_ADDR, 8'h92);
    repeat (3) @(negedge i_clk_sys);
    check("settled_kept", 62'(settled), 62'd1);
    $display("test resettle done");
    stop_test();
  end
endmodule

`default_nettype wire
